/* File: rtl/crf_pkg.sv */
// Shared constants and carrier types of the CPU register file and flag word.
// Assumes a single 100 MHz clock and a synchronous active-high reset.
`default_nettype none
package crf_pkg;
    localparam int unsigned CRF_ADDR_W = 5;
    localparam int unsigned CRF_DATA_W = 32;

    // Register map, word offsets on the register port
    localparam logic [4:0] ADDR_GP0 = 5'h00;
    localparam logic [4:0] ADDR_GP1 = 5'h01;
    localparam logic [4:0] ADDR_GP2 = 5'h02;
    localparam logic [4:0] ADDR_GP3 = 5'h03;
    localparam logic [4:0] ADDR_AX0 = 5'h04;
    localparam logic [4:0] ADDR_AX1 = 5'h05;
    localparam logic [4:0] ADDR_FB = 5'h06;
    localparam logic [4:0] ADDR_VECTOR_TABLE_BASE = 5'h07;
    localparam logic [4:0] ADDR_PC = 5'h08;
    localparam logic [4:0] ADDR_USP = 5'h09;
    localparam logic [4:0] ADDR_ISP = 5'h0a;
    localparam logic [4:0] ADDR_SB = 5'h0b;
    localparam logic [4:0] ADDR_PSW = 5'h0c;
    localparam logic [4:0] ADDR_GP0_LO = 5'h10;
    localparam logic [4:0] ADDR_GP0_HI = 5'h11;
    localparam logic [4:0] ADDR_GP1_LO = 5'h12;
    localparam logic [4:0] ADDR_GP1_HI = 5'h13;
    localparam logic [4:0] ADDR_PAIR_LO = 5'h14;
    localparam logic [4:0] ADDR_PAIR_HI = 5'h15;
    localparam logic [4:0] ADDR_AX_PAIR = 5'h16;
    localparam logic [4:0] ADDR_SP = 5'h17;

    // Flag word placement in the 16-bit read view
    localparam int unsigned PSW_IPL_LSB = 12;
    localparam int unsigned PSW_IPL_W = 3;
    localparam logic [5:0] SWI_STACK_LIMIT = 6'h20;
    localparam logic [19:0] PC_RESET = 20'h00000;

    typedef struct packed {
        logic [2:0] priority_level_field;
        logic u;
        logic i;
        logic o;
        logic b;
        logic s;
        logic z;
        logic d;
        logic c;
    } crf_flags_t;

    localparam crf_flags_t FLAGS_RESET = '0;

    typedef struct packed {
        logic [4:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } crf_bus_t;

    typedef struct packed {
        logic valid;
        logic byte_op;
        logic [15:0] result;
        logic carry;
        logic overflow;
    } crf_alu_t;

    typedef struct packed {
        logic req;
        logic nmi;
        logic [2:0] level;
        logic swi;
        logic [5:0] swi_num;
    } crf_irq_t;
endpackage
`default_nettype wire

/* File: rtl/crf_flag_calc.sv */
// Zero and sign evaluation of an ALU result, word or byte wide.
// Assumes the result arrives on the same clock as the register file.
`default_nettype none
module crf_flag_calc
    import crf_pkg::*;
(
    input wire crf_alu_t alu,
    output logic zero,
    output logic sign
);
    always_comb
    begin
        if (alu.byte_op)
        begin
            zero = (alu.result[7:0] == 8'h00);
            sign = alu.result[7];
        end
        else
        begin
            zero = (alu.result == 16'h0000);
            sign = alu.result[15];
        end
    end
endmodule // crf_flag_calc
`default_nettype wire

/* File: rtl/crf_int_gate.sv */
// Decides whether an interrupt request is taken this cycle.
// Assumes request fields are stable and on the register file clock.
`default_nettype none
module crf_int_gate
    import crf_pkg::*;
(
    input wire crf_irq_t irq,
    input wire crf_flags_t flags,
    output logic accept
);
    logic above_level;

    always_comb
    begin
        above_level = (irq.level > flags.priority_level_field);
        // Non-maskable sources bypass both the enable flag and the level
        accept = irq.req && (irq.nmi || (flags.i && above_level));
    end
endmodule // crf_int_gate
`default_nettype wire

/* File: rtl/crf_top.sv */
// CPU register set: two banks of data/address/frame registers, bases,
// program counter, two stack pointers and the 11-bit flag word.
// Assumes the datapath and interrupt logic share ref_clk with this block.
//
// Notes on behaviour
// - Four 16-bit general data registers
// - First two split into byte halves
// - Third/fourth pair above first/second as 32-bit
// - Two 16-bit address registers
// - Address registers pair, second is upper
// - 16-bit frame base register
// - 20-bit vector table base register
// - 20-bit program counter, next instruction
// - Two stack pointers, one active
// - 16-bit static base register
// - 11-bit flag word of processor state
// - Carry holds ALU carry, borrow, shift-out
// - Zero flag set on zero result
// - Sign flag set on negative result
// - Bank flag picks register bank
// - Overflow flag set on overflow
// - Interrupt enable flag gates maskable interrupts
// - Acknowledge clears interrupt enable flag
// - Stack select flag picks active pointer
// - Interrupts and low software numbers clear stack select
// - Maskable request accepted only above priority level
`default_nettype none
module crf_top
    import crf_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire crf_bus_t bus,
    output logic [31:0] rdata,
    input wire crf_alu_t alu,
    input wire crf_irq_t irq,
    input wire logic pc_advance,
    input wire logic [2:0] pc_step,
    output crf_flags_t flags,
    output logic [19:0] pc,
    output logic [15:0] active_sp,
    output logic int_ack
);
    typedef struct packed {
        logic [1:0][3:0][15:0] gp;
        logic [1:0][1:0][15:0] ax;
        logic [1:0][15:0] fb;
        logic [19:0] vector_table_base;
        logic [19:0] pc;
        logic [15:0] user_stack_pointer;
        logic [15:0] interrupt_stack_pointer;
        logic [15:0] sb;
        crf_flags_t processor_state_word;
        logic [15:0] sp_out;
        logic ack;
        logic [31:0] rdata;
    } crf_state_t;

    crf_state_t q, d;
    logic zero_res, sign_res, accept;
    logic bk;

    function automatic logic [15:0] psw_view(input crf_flags_t f);
        logic [15:0] w;
        w = '0;
        w[7:0] = {f.u, f.i, f.o, f.b, f.s, f.z, f.d, f.c};
        w[PSW_IPL_LSB +: PSW_IPL_W] = f.priority_level_field;
        return w;
    endfunction

    function automatic crf_flags_t psw_load(input logic [15:0] w);
        crf_flags_t f;
        f = '0;
        {f.u, f.i, f.o, f.b, f.s, f.z, f.d, f.c} = w[7:0];
        f.priority_level_field = w[PSW_IPL_LSB +: PSW_IPL_W];
        return f;
    endfunction

    crf_flag_calc u_flag_calc (
        .alu(alu),
        .zero(zero_res),
        .sign(sign_res)
    );

    crf_int_gate u_int_gate (
        .irq(irq),
        .flags(q.processor_state_word),
        .accept(accept)
    );

    assign bk = q.processor_state_word.b;

    always_comb
    begin
        d = q;
        d.ack = 1'b0;
        d.rdata = '0;
        if (bus.rd)
        begin
            unique case (bus.addr)
                ADDR_GP0: d.rdata = {16'h0000, q.gp[bk][0]};
                ADDR_GP1: d.rdata = {16'h0000, q.gp[bk][1]};
                ADDR_GP2: d.rdata = {16'h0000, q.gp[bk][2]};
                ADDR_GP3: d.rdata = {16'h0000, q.gp[bk][3]};
                ADDR_AX0: d.rdata = {16'h0000, q.ax[bk][0]};
                ADDR_AX1: d.rdata = {16'h0000, q.ax[bk][1]};
                ADDR_FB: d.rdata = {16'h0000, q.fb[bk]};
                ADDR_VECTOR_TABLE_BASE: d.rdata = {12'h000, q.vector_table_base};
                ADDR_PC: d.rdata = {12'h000, q.pc};
                ADDR_USP: d.rdata = {16'h0000, q.user_stack_pointer};
                ADDR_ISP: d.rdata = {16'h0000, q.interrupt_stack_pointer};
                ADDR_SB: d.rdata = {16'h0000, q.sb};
                ADDR_PSW: d.rdata = {16'h0000, psw_view(q.processor_state_word)};
                ADDR_GP0_LO: d.rdata = {24'h000000, q.gp[bk][0][7:0]};
                ADDR_GP0_HI: d.rdata = {24'h000000, q.gp[bk][0][15:8]};
                ADDR_GP1_LO: d.rdata = {24'h000000, q.gp[bk][1][7:0]};
                ADDR_GP1_HI: d.rdata = {24'h000000, q.gp[bk][1][15:8]};
                ADDR_PAIR_LO: d.rdata = {q.gp[bk][2], q.gp[bk][0]};
                ADDR_PAIR_HI: d.rdata = {q.gp[bk][3], q.gp[bk][1]};
                ADDR_AX_PAIR: d.rdata = {q.ax[bk][1], q.ax[bk][0]};
                ADDR_SP: d.rdata = {16'h0000, q.sp_out};
                default: d.rdata = '0;
            endcase
        end
        if (bus.wr)
        begin
            unique case (bus.addr)
                ADDR_GP0: d.gp[bk][0] = bus.wdata[15:0];
                ADDR_GP1: d.gp[bk][1] = bus.wdata[15:0];
                ADDR_GP2: d.gp[bk][2] = bus.wdata[15:0];
                ADDR_GP3: d.gp[bk][3] = bus.wdata[15:0];
                ADDR_AX0: d.ax[bk][0] = bus.wdata[15:0];
                ADDR_AX1: d.ax[bk][1] = bus.wdata[15:0];
                ADDR_FB: d.fb[bk] = bus.wdata[15:0];
                ADDR_VECTOR_TABLE_BASE: d.vector_table_base = bus.wdata[19:0];
                ADDR_PC: d.pc = bus.wdata[19:0];
                ADDR_USP: d.user_stack_pointer = bus.wdata[15:0];
                ADDR_ISP: d.interrupt_stack_pointer = bus.wdata[15:0];
                ADDR_SB: d.sb = bus.wdata[15:0];
                // Debug bit is stored as written; software keeps it clear
                ADDR_PSW: d.processor_state_word = psw_load(bus.wdata[15:0]);
                ADDR_GP0_LO: d.gp[bk][0][7:0] = bus.wdata[7:0];
                ADDR_GP0_HI: d.gp[bk][0][15:8] = bus.wdata[7:0];
                ADDR_GP1_LO: d.gp[bk][1][7:0] = bus.wdata[7:0];
                ADDR_GP1_HI: d.gp[bk][1][15:8] = bus.wdata[7:0];
                ADDR_PAIR_LO:
                begin
                    d.gp[bk][0] = bus.wdata[15:0];
                    d.gp[bk][2] = bus.wdata[31:16];
                end
                ADDR_PAIR_HI:
                begin
                    d.gp[bk][1] = bus.wdata[15:0];
                    d.gp[bk][3] = bus.wdata[31:16];
                end
                ADDR_AX_PAIR:
                begin
                    d.ax[bk][0] = bus.wdata[15:0];
                    d.ax[bk][1] = bus.wdata[31:16];
                end
                ADDR_SP:
                begin
                    if (q.processor_state_word.u)
                        d.user_stack_pointer = bus.wdata[15:0];
                    else
                        d.interrupt_stack_pointer = bus.wdata[15:0];
                end
                default:
                begin
                end
            endcase
        end
        // A PC write from software outranks the sequential step
        if (pc_advance && !(bus.wr && bus.addr == ADDR_PC))
            d.pc = q.pc + {17'h00000, pc_step};
        // ALU outcome wins over a software write of the same flags
        if (alu.valid)
        begin
            d.processor_state_word.c = alu.carry;
            d.processor_state_word.z = zero_res;
            d.processor_state_word.s = sign_res;
            d.processor_state_word.o = alu.overflow;
        end
        // Interrupt entry must not be undone by a racing flag write
        if (accept)
        begin
            d.ack = 1'b1;
            d.processor_state_word.i = 1'b0;
            d.processor_state_word.u = 1'b0;
        end
        else if (irq.swi)
        begin
            d.processor_state_word.i = 1'b0;
            if (irq.swi_num < SWI_STACK_LIMIT)
                d.processor_state_word.u = 1'b0;
        end
        d.sp_out = d.processor_state_word.u ? d.user_stack_pointer : d.interrupt_stack_pointer;
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            q <= '0;
            q.pc <= PC_RESET;
            q.processor_state_word <= FLAGS_RESET;
        end
        else
            q <= d;
    end

    assign rdata = q.rdata;
    assign flags = q.processor_state_word;
    assign pc = q.pc;
    assign active_sp = q.sp_out;
    assign int_ack = q.ack;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);

    read_pc_data_a: assert property (
        bus.rd && bus.addr == ADDR_PC |=> rdata == {12'h000, $past(q.pc)})
        else $error("PC read data wrong");

    read_idle_zero_a: assert property (
        !bus.rd |=> rdata == 32'h00000000)
        else $error("read data not zero outside read answer");

    zero_flag_a: assert property (
        alu.valid && !alu.byte_op |=> flags.z == ($past(alu.result) == 16'h0000))
        else $error("zero flag mismatch");

    sign_flag_a: assert property (
        alu.valid && alu.byte_op |=> flags.s == $past(alu.result[7]))
        else $error("byte sign flag mismatch");

    carry_overflow_a: assert property (
        alu.valid |=> flags.c == $past(alu.carry) && flags.o == $past(alu.overflow))
        else $error("carry or overflow not captured");

    ack_clears_flags_a: assert property (
        int_ack |-> !flags.i && !flags.u)
        else $error("acknowledge left I or U set");

    accept_gate_a: assert property (
        int_ack |-> $past(irq.req) && ($past(irq.nmi) ||
            ($past(flags.i) && $past(irq.level) > $past(flags.priority_level_field))))
        else $error("interrupt taken without enable or priority");

    masked_refused_a: assert property (
        irq.req && !irq.nmi && !flags.i |=> !int_ack)
        else $error("masked interrupt acknowledged");

    byte_keep_a: assert property (
        bus.wr && bus.addr == ADDR_GP0_LO && !alu.valid |=>
            q.gp[$past(bk)][0] == {$past(q.gp[bk][0][15:8]), $past(bus.wdata[7:0])})
        else $error("byte write disturbed other half");

    pair_write_a: assert property (
        bus.wr && bus.addr == ADDR_PAIR_LO |=> {q.gp[$past(bk)][2], q.gp[$past(bk)][0]} == $past(bus.wdata))
        else $error("long pair write mismatch");

    swi_stack_a: assert property (
        irq.swi && irq.swi_num < SWI_STACK_LIMIT |=> !flags.u && !flags.i)
        else $error("software interrupt kept user stack");

    sp_select_a: assert property (
        active_sp == (flags.u ? q.user_stack_pointer : q.interrupt_stack_pointer))
        else $error("active stack pointer mismatch");

    irq_taken_c: cover property (irq.req && !irq.nmi ##1 int_ack);
    swi_entry_c: cover property (flags.u ##1 irq.swi ##1 !flags.u);
    bank_switch_c: cover property (!flags.b ##1 flags.b ##1 bus.rd && bus.addr == ADDR_GP0);
    pair_write_c: cover property (bus.wr && bus.addr == ADDR_PAIR_HI);
endmodule // crf_top
`default_nettype wire

/* File: dv/crf_partner.sv */
// Model of the datapath-side interrupt requester facing the register set.
// Assumes requests are held by the bench and share ref_clk with the design.
`default_nettype none
module crf_partner
    import crf_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic int_ack,
    input wire logic req_in,
    input wire logic nmi_in,
    input wire logic [2:0] lvl_in,
    input wire logic swi_in,
    input wire logic [5:0] num_in,
    output crf_irq_t irq
);
    logic served_q;
    always_ff @(posedge ref_clk)
    begin
        if (reset || !req_in)
            served_q <= 1'b0;
        else if (int_ack)
            served_q <= 1'b1;
    end
    // Withdrawn in the acknowledge cycle, else a non-maskable request would be taken twice
    assign irq = '{req: req_in && !served_q && !int_ack, nmi: nmi_in, level: lvl_in, swi: swi_in, swi_num: num_in};
endmodule // crf_partner
`default_nettype wire

/* File: dv/testbench.sv */
// Self-checking bench for the CPU register set and flag word.
// Assumes the design package, the design and crf_partner are compiled first.
`default_nettype none
module testbench
    import crf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk, reset, pc_advance, int_ack, req_in, nmi_in, swi_in;
    logic [2:0] pc_step, lvl_in;
    logic [5:0] num_in;
    logic [31:0] rdata;
    logic [19:0] pc;
    logic [15:0] active_sp;
    crf_bus_t bus;
    crf_alu_t alu;
    crf_irq_t irq;
    crf_flags_t flags;
    int fails, n_tests;

    crf_top uut (.ref_clk(ref_clk), .reset(reset), .bus(bus), .rdata(rdata), .alu(alu), .irq(irq),
        .pc_advance(pc_advance), .pc_step(pc_step), .flags(flags), .pc(pc), .active_sp(active_sp),
        .int_ack(int_ack));
    crf_partner partner (.ref_clk(ref_clk), .reset(reset), .int_ack(int_ack), .req_in(req_in),
        .nmi_in(nmi_in), .lvl_in(lvl_in), .swi_in(swi_in), .num_in(num_in), .irq(irq));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            fails++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        bus.wr <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, input logic [31:0] exp);
        @(posedge ref_clk);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk);
        bus.rd <= 1'b0;
        #1 chk(rdata, exp);
    endtask
    task automatic op(input logic b, input logic [15:0] r, input logic c, input logic o, input logic [10:0] e);
        @(posedge ref_clk);
        alu <= '{valid: 1'b1, byte_op: b, result: r, carry: c, overflow: o};
        @(posedge ref_clk);
        alu.valid <= 1'b0;
        #1 chk({21'h0, flags}, {21'h0, e});
    endtask
    task automatic irq_try(input logic [2:0] l, input logic n, input int e);
        int seen;
        seen = 0;
        @(posedge ref_clk);
        req_in <= 1'b1;
        lvl_in <= l;
        nmi_in <= n;
        repeat (4)
        begin
            @(posedge ref_clk);
            if (int_ack === 1'b1)
                seen++;
        end
        req_in <= 1'b0;
        chk(seen, e);
    endtask
    task automatic swi(input logic [5:0] n, input logic [10:0] e);
        wr(ADDR_PSW, 32'h00c0);
        @(posedge ref_clk);
        swi_in <= 1'b1;
        num_in <= n;
        @(posedge ref_clk);
        swi_in <= 1'b0;
        #1 chk({21'h0, flags}, {21'h0, e});
    endtask
    task automatic test_done();
        $display("tests %0d failures %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic t_regs();
        rd(ADDR_PSW, 32'h0);
        rd(ADDR_PC, 32'h0);
        // Registers GP0 to SB with non-zero upper bits 16'hfedc, to catch width slips and aliasing
        for (int a = 0; a < 12; a++)
            wr(a[4:0], 32'hfedcba90 + a);
        wr(5'h1f, 32'h12345678);
        for (int a = 0; a < 12; a++)
            rd(a[4:0], (32'hfedcba90 + a) & ((a == 7 || a == 8) ? 32'hfffff : 32'hffff));
        rd(5'h1f, 32'h0);
    endtask
    task automatic t_bytes();
        for (int k = 0; k < 2; k++)
        begin
            wr(ADDR_GP0 + k[4:0], 32'h1234);
            wr(ADDR_GP0_LO + 5'(2 * k), 32'hffffffab);
            rd(ADDR_GP0 + k[4:0], 32'h12ab);
            wr(ADDR_GP0_HI + 5'(2 * k), 32'h00cd);
            rd(ADDR_GP0 + k[4:0], 32'hcdab);
            rd(ADDR_GP0_HI + 5'(2 * k), 32'hcd);
        end
    endtask
    task automatic t_pairs();
        wr(ADDR_PAIR_LO, 32'h89abcdef);
        rd(ADDR_GP2, 32'h89ab);
        rd(ADDR_GP0, 32'hcdef);
        wr(ADDR_PAIR_HI, 32'h01234567);
        rd(ADDR_GP3, 32'h0123);
        rd(ADDR_GP1, 32'h4567);
        wr(ADDR_AX_PAIR, 32'h76543210);
        rd(ADDR_AX1, 32'h7654);
        rd(ADDR_AX_PAIR, 32'h76543210);
    endtask
    task automatic t_bank();
        wr(ADDR_PSW, 32'h0010);
        rd(ADDR_PSW, 32'h0010);
        rd(ADDR_GP0, 32'h0);
        wr(ADDR_GP0, 32'h5555);
        rd(ADDR_GP0, 32'h5555);
        wr(ADDR_PSW, 32'h0);
        rd(ADDR_GP0, 32'hcdef);
    endtask
    task automatic t_alu();
        op(1'b0, 16'h0000, 1'b0, 1'b0, 11'h004);
        op(1'b0, 16'h8000, 1'b1, 1'b1, 11'h029);
        op(1'b1, 16'h0080, 1'b0, 1'b0, 11'h008);
        op(1'b1, 16'h0100, 1'b1, 1'b0, 11'h005);
        op(1'b0, 16'h0100, 1'b0, 1'b0, 11'h000);
    endtask
    task automatic t_stack();
        wr(ADDR_USP, 32'h1111);
        wr(ADDR_ISP, 32'h2222);
        wr(ADDR_PSW, 32'h0080);
        #1 chk(active_sp, 32'h1111);
        wr(ADDR_PSW, 32'h0);
        #1 chk(active_sp, 32'h2222);
        wr(ADDR_SP, 32'h3333);
        rd(ADDR_ISP, 32'h3333);
        rd(ADDR_USP, 32'h1111);
    endtask
    task automatic t_irq();
        wr(ADDR_PSW, 32'h30c0);
        irq_try(3'h3, 1'b0, 0);
        irq_try(3'h4, 1'b0, 1);
        #1 chk({21'h0, flags}, 32'h300);
        irq_try(3'h7, 1'b0, 0);
        irq_try(3'h0, 1'b1, 1);
    endtask
    task automatic t_swi();
        swi(6'h00, 11'h000);
        swi(6'h1f, 11'h000);
        swi(6'h20, 11'h080);
    endtask
    task automatic t_pc();
        wr(ADDR_PC, 32'hffffe);
        @(posedge ref_clk);
        pc_advance <= 1'b1;
        pc_step <= 3'h3;
        @(posedge ref_clk);
        pc_advance <= 1'b0;
        #1 chk(pc, 32'h1);
    endtask
    // Reset in mid-run must bring every register and output back to zero
    task automatic t_reset();
        @(posedge ref_clk);
        reset <= 1'b1;
        repeat (2) @(posedge ref_clk);
        reset <= 1'b0;
        #1 chk({21'h0, flags}, 32'h0);
        chk(pc, 32'h0);
        chk(active_sp, 32'h0);
        chk(int_ack, 32'h0);
        chk(rdata, 32'h0);
        rd(ADDR_GP0, 32'h0);
        rd(ADDR_USP, 32'h0);
    endtask

    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    initial
    begin
        #200000;
        fails++;
        test_done();
    end
    initial
    begin
        reset = 1'b1;
        bus = '0;
        alu = '0;
        pc_advance = 1'b0;
        pc_step = 3'h0;
        req_in = 1'b0;
        nmi_in = 1'b0;
        lvl_in = 3'h0;
        swi_in = 1'b0;
        num_in = 6'h00;
        fails = 0;
        n_tests = 0;
        repeat (20) @(posedge ref_clk);
        reset <= 1'b0;
        t_regs();
        t_bytes();
        t_pairs();
        t_bank();
        t_alu();
        t_stack();
        t_irq();
        t_swi();
        t_pc();
        t_reset();
        test_done();
    end
endmodule // testbench
`default_nettype wire
